// ==== pkg/dea_map.svh ====
// Named constants for the data EEPROM access controller: offsets, bit positions, resets, timing.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef DEA_MAP_SVH
`define DEA_MAP_SVH

// Avalon byte offsets of the directly reached registers (one aligned word each).
`define DEA_OFF_ADDRESS      8'h00
`define DEA_OFF_DATA         8'h04
`define DEA_OFF_PTR_LOW      8'h08
`define DEA_OFF_PTR_HIGH     8'h0C
`define DEA_OFF_INDIRECT     8'h10
`define DEA_OFF_STATUS       8'h14

// Pointer values that select the control register through the indirect port.
`define DEA_CTRL_PTR_LOW     8'h40
`define DEA_CTRL_PTR_HIGH    8'h01

// Control register bit positions.
`define DEA_CTRL_READ_START  0
`define DEA_CTRL_READ_PERMIT 1
`define DEA_CTRL_WRITE_START 2
`define DEA_CTRL_WRITE_PERM  3

// Status register bit positions.
`define DEA_STAT_DONE        0
`define DEA_STAT_MF          1
`define DEA_STAT_FAIL        2
`define DEA_STAT_BUSY        3

// Reset values.
`define DEA_RST_BYTE         8'h00
`define DEA_RST_ADDR         6'h00
`define DEA_RST_WORD         32'h0000_0000

// Storage geometry.
`define DEA_DEPTH            64
`define DEA_ADDR_W           6
`define DEA_DATA_W           8

// Timing: system clock rate, read cycle length in clocks, write cycle time in microseconds.
`define DEA_CLK_HZ           10000000
`define DEA_US_PER_S         1000000
`define DEA_READ_CYCLES      2
`define DEA_WRITE_TIME_US    2000

`endif

// ==== pkg/dea_pkg.sv ====
// Types shared by the data EEPROM access controller.
// Assumes nothing beyond a SystemVerilog compiler; constants live in dea_map.svh.
package dea_pkg;

  // Cycle sequencer states.
  typedef enum logic [1:0] {
    DEA_IDLE,
    DEA_READING,
    DEA_WRITING
  } dea_state_t;

endpackage : dea_pkg

// ==== verilog/dea_nvm_array.sv ====
// Byte storage of the data EEPROM, held in flip-flops and addressed by an index.
// Assumes one clock; the write strobe is a single-cycle pulse from the sequencer.
`timescale 1ns/1ps
`include "dea_map.svh"

module dea_nvm_array #(
  parameter int DEPTH  = `DEA_DEPTH,
  parameter int ADDR_W = `DEA_ADDR_W,
  parameter int DATA_W = `DEA_DATA_W
) (
  // Clock.
  input  wire logic              clk,
  // Read side.
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  // Write side.
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data
);

  // Every index of the address field must name a cell.
  if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
    $error("dea_nvm_array: DEPTH must equal 2**ADDR_W");
  end

  // Storage is not reset: the contents are meant to survive a reset.
  logic [DATA_W-1:0] mem [DEPTH];

  // Read path is a plain selection.
  assign rd_data = mem[rd_addr];

  // Write one cell.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule // dea_nvm_array

// ==== verilog/dea_write_timer.sv ====
// Write cycle timer: a microsecond enable divider and a tick counter.
// Assumes a single-cycle start pulse and an abort level from the sequencer.
`timescale 1ns/1ps
`include "dea_map.svh"

module dea_write_timer #(
  parameter int TICK_CYCLES = `DEA_CLK_HZ / `DEA_US_PER_S,
  parameter int TIME_US     = `DEA_WRITE_TIME_US
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Control.
  input  wire logic start,
  input  wire logic abort,
  // Status.
  output logic      busy,
  output logic      done
);

  // Counters are 16 bits wide.
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || TIME_US < 1 || TIME_US > 65535) begin : g_bad
    $error("dea_write_timer: counts must lie in 1..65535");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] TIME_LAST = 16'(TIME_US - 1);

  logic [15:0] div_cnt;
  logic [15:0] us_cnt;
  wire         tick = busy && (div_cnt == TICK_LAST);

  // Done is a pulse on the last microsecond tick.
  assign done = tick && (us_cnt == TIME_LAST) && !abort;

  // Divider restarts with each cycle so every write lasts the full time.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy    <= 1'b0;
      div_cnt <= 16'h0000;
      us_cnt  <= 16'h0000;
    end else if (start) begin
      busy    <= 1'b1;
      div_cnt <= 16'h0000;
      us_cnt  <= 16'h0000;
    end else if (abort || done) begin
      busy    <= 1'b0;
    end else if (busy) begin
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
      us_cnt  <= tick ? us_cnt + 16'h0001 : us_cnt;
    end
  end

endmodule // dea_write_timer

// ==== verilog/dea_access_ctrl.sv ====
// Data EEPROM access controller: Avalon-MM register slave, cycle sequencer, flags.
// Assumes a single 10 MHz clock, an asynchronous active-high reset and inputs
// synchronous to that clock; low power and service requests come from the core.
//
// What this block does
// - Low-power entry during a cycle makes it fail; core waits for busy to drop.
// - Control register is reached via indirect port with pointers 40h low, 01h high.
// - Control bit 1 permits reads, bit 0 starts a read.
// - Control bit 3 permits writes, bit 2 starts a write.
// - Read start bit stays high while a read cycle runs.
// - Write start bit stays high for the whole write cycle.
// - Writing zero to the control register clears both permit bits.
// - After a read ends the data register holds the fetched byte.
// - Hardware clears start bits at cycle end; start needs its permit already set.
// - Storage is 64 bytes; address bits 7 and 6 read as zero.
// - A finished write sets the done flag and the multi-function flag.
// - Control bits reset to zero; write length comes from an internal timer.
`timescale 1ns/1ps
`include "dea_map.svh"

module dea_access_ctrl #(
  parameter int READ_CYCLES   = `DEA_READ_CYCLES,
  parameter int WRITE_TIME_US = `DEA_WRITE_TIME_US
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Core side.
  input  wire logic        low_power_request,
  input  wire logic        mf_serviced,
  output logic             nvm_busy,
  output logic             program_done_flag,
  output logic             mf_request_flag,
  output logic             op_failed_flag
);

  // The read counter is eight bits wide.
  if (READ_CYCLES < 1 || READ_CYCLES > 255) begin : g_bad_read
    $error("dea_access_ctrl: READ_CYCLES must lie in 1..255");
  end

  localparam logic [7:0] READ_LAST = 8'(READ_CYCLES - 1);

  // ------------------------------------------------------------------
  // Register state.
  // ------------------------------------------------------------------
  logic [`DEA_ADDR_W-1:0] nvm_address_reg;
  logic [`DEA_DATA_W-1:0] nvm_data_reg;
  logic [7:0]             pointer_low;
  logic [7:0]             pointer_high;
  logic                   program_permit;
  logic                   fetch_permit;
  logic                   phase;
  logic [7:0]             read_cnt;
  logic [`DEA_ADDR_W-1:0] wr_addr_hold;
  logic [`DEA_DATA_W-1:0] wr_data_hold;
  dea_pkg::dea_state_t    state;
  dea_pkg::dea_state_t    next_state;

  // ------------------------------------------------------------------
  // Bus handshake: one wait state per access, so read data can come
  // from a flip-flop loaded in the first cycle.
  // ------------------------------------------------------------------
  wire bus_req    = avs_read || avs_write;
  wire bus_accept = bus_req && phase;
  wire rd_load    = avs_read && !phase;
  wire wr_take    = avs_write && phase && avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];

  assign avs_waitrequest = bus_req && !phase;

  // Address decode.
  wire sel_address = (avs_address == `DEA_OFF_ADDRESS);
  wire sel_data    = (avs_address == `DEA_OFF_DATA);
  wire sel_ptr_lo  = (avs_address == `DEA_OFF_PTR_LOW);
  wire sel_ptr_hi  = (avs_address == `DEA_OFF_PTR_HIGH);
  wire sel_ind     = (avs_address == `DEA_OFF_INDIRECT);
  wire sel_status  = (avs_address == `DEA_OFF_STATUS);

  // The indirect port reaches the control register only at the one pointer value.
  wire ctrl_hit = (pointer_low == `DEA_CTRL_PTR_LOW) && (pointer_high == `DEA_CTRL_PTR_HIGH);

  // Control register write strobes and field views.
  wire ctrl_wr      = wr_take && sel_ind && ctrl_hit;
  wire w_rd_start   = wbyte[`DEA_CTRL_READ_START];
  wire w_wr_start   = wbyte[`DEA_CTRL_WRITE_START];
  wire both_start   = w_rd_start && w_wr_start;
  wire ctrl_take    = ctrl_wr && !both_start;

  // A start needs its permit already set and an idle sequencer.
  wire start_read  = ctrl_take && w_rd_start && fetch_permit && (state == dea_pkg::DEA_IDLE);
  wire start_write = ctrl_take && w_wr_start && program_permit
                     && (state == dea_pkg::DEA_IDLE);

  // Start bits read back as the sequencer state.
  wire read_start_bit  = (state == dea_pkg::DEA_READING);
  wire write_start_bit = (state == dea_pkg::DEA_WRITING);

  // Low power entry kills any cycle in progress.
  wire abort = low_power_request && (state != dea_pkg::DEA_IDLE);

  // ------------------------------------------------------------------
  // Storage and timer.
  // ------------------------------------------------------------------
  wire [`DEA_DATA_W-1:0] array_rd_data;
  wire                   timer_done;
  wire                   read_end = (state == dea_pkg::DEA_READING) && (read_cnt == READ_LAST)
                                    && !abort;
  wire                   write_end = (state == dea_pkg::DEA_WRITING) && timer_done;

  dea_nvm_array #(
    .DEPTH  (`DEA_DEPTH),
    .ADDR_W (`DEA_ADDR_W),
    .DATA_W (`DEA_DATA_W)
  ) u_array (
    .clk     (clk),
    .rd_addr (nvm_address_reg),
    .rd_data (array_rd_data),
    .wr_en   (write_end),
    .wr_addr (wr_addr_hold),
    .wr_data (wr_data_hold)
  );

  // The write length is owned by the timer, not by the bus.
  dea_write_timer #(
    .TICK_CYCLES (`DEA_CLK_HZ / `DEA_US_PER_S),
    .TIME_US     (WRITE_TIME_US)
  ) u_timer (
    .clk   (clk),
    .reset (reset),
    .start (start_write),
    .abort (abort),
    .busy  (),
    .done  (timer_done)
  );

  // ------------------------------------------------------------------
  // Sequencer next state.
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      dea_pkg::DEA_IDLE: begin
        if (start_read) begin
          next_state = dea_pkg::DEA_READING;
        end else if (start_write) begin
          next_state = dea_pkg::DEA_WRITING;
        end
      end
      dea_pkg::DEA_READING: begin
        if (read_end || abort) begin
          next_state = dea_pkg::DEA_IDLE;
        end
      end
      dea_pkg::DEA_WRITING: begin
        if (write_end || abort) begin
          next_state = dea_pkg::DEA_IDLE;
        end
      end
      // The fourth code is illegal; falling back to idle recovers from it.
      default: begin
        next_state = dea_pkg::DEA_IDLE;
      end
    endcase
  end

  // Sequencer state and read length counter.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state    <= dea_pkg::DEA_IDLE;
      read_cnt <= 8'h00;
    end else begin
      state    <= next_state;
      read_cnt <= (state == dea_pkg::DEA_READING) ? read_cnt + 8'h01 : 8'h00;
    end
  end

  // Address and data of a write are frozen at its start, so software
  // touching them mid-cycle cannot corrupt the stored byte.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_addr_hold <= `DEA_RST_ADDR;
      wr_data_hold <= `DEA_RST_BYTE;
    end else if (start_write) begin
      wr_addr_hold <= nvm_address_reg;
      wr_data_hold <= nvm_data_reg;
    end
  end

  // ------------------------------------------------------------------
  // Software registers.
  // ------------------------------------------------------------------

  // Address register keeps only the six implemented bits.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nvm_address_reg <= `DEA_RST_ADDR;
    end else if (wr_take && sel_address) begin
      nvm_address_reg <= wbyte[`DEA_ADDR_W-1:0];
    end
  end

  // The fetched byte wins over a software write landing in the same cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nvm_data_reg <= `DEA_RST_BYTE;
    end else if (read_end) begin
      nvm_data_reg <= array_rd_data;
    end else if (wr_take && sel_data) begin
      nvm_data_reg <= wbyte;
    end
  end

  // Memory pointers reset to zero, which keeps the control register out of reach.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pointer_low  <= `DEA_RST_BYTE;
      pointer_high <= `DEA_RST_BYTE;
    end else if (wr_take && sel_ptr_lo) begin
      pointer_low  <= wbyte;
    end else if (wr_take && sel_ptr_hi) begin
      pointer_high <= wbyte;
    end
  end

  // Permit bits follow every control write that does not set both start bits; a zero write clears both.
  // Clearing a permit does not stop a cycle that is already running.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      program_permit <= 1'b0;
      fetch_permit   <= 1'b0;
    end else if (ctrl_take) begin
      program_permit <= wbyte[`DEA_CTRL_WRITE_PERM];
      fetch_permit   <= wbyte[`DEA_CTRL_READ_PERMIT];
    end
  end

  // ------------------------------------------------------------------
  // Flags: set wins over clear for each of them.
  // ------------------------------------------------------------------
  wire stat_wr    = wr_take && sel_status;
  wire clr_done   = stat_wr && wbyte[`DEA_STAT_DONE];
  wire clr_fail   = stat_wr && wbyte[`DEA_STAT_FAIL];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      program_done_flag <= 1'b0;
      mf_request_flag   <= 1'b0;
      op_failed_flag    <= 1'b0;
    end else begin
      program_done_flag <= write_end || (program_done_flag && !clr_done);
      mf_request_flag   <= write_end || (mf_request_flag && !mf_serviced);
      op_failed_flag    <= abort || (op_failed_flag && !clr_fail);
    end
  end

  // The core must not enter a low power mode while this is high.
  assign nvm_busy = (state != dea_pkg::DEA_IDLE);

  // ------------------------------------------------------------------
  // Read mux; unmapped offsets and a closed indirect port read zero.
  // ------------------------------------------------------------------
  wire [7:0] ctrl_value = {4'h0, program_permit, write_start_bit, fetch_permit, read_start_bit};
  wire [7:0] stat_value = {4'h0, nvm_busy, op_failed_flag, mf_request_flag, program_done_flag};
  wire [7:0] ind_value  = ctrl_hit ? ctrl_value : `DEA_RST_BYTE;
  wire [7:0] rd_byte    = sel_address ? {2'b00, nvm_address_reg} :
                          sel_data    ? nvm_data_reg :
                          sel_ptr_lo  ? pointer_low :
                          sel_ptr_hi  ? pointer_high :
                          sel_ind     ? ind_value :
                          sel_status  ? stat_value : `DEA_RST_BYTE;

  // Handshake phase and registered read data.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase        <= 1'b0;
      avs_readdata <= `DEA_RST_WORD;
    end else begin
      phase        <= bus_req && !phase && !bus_accept;
      if (rd_load) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule // dea_access_ctrl

// ==== test/dea_access_ctrl_checker.sv ====
// Concurrent checks on the ports of the data EEPROM access controller.
// Assumes one clock, an asynchronous active-high reset and a master that holds requests.
`timescale 1ns/1ps
`include "dea_map.svh"

module dea_access_ctrl_checker #(
  parameter int READ_CYCLES   = `DEA_READ_CYCLES,
  parameter int WRITE_TIME_US = `DEA_WRITE_TIME_US
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset,
  // Avalon-MM slave.
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Core side.
  input wire logic        low_power_request,
  input wire logic        mf_serviced,
  input wire logic        nvm_busy,
  input wire logic        program_done_flag,
  input wire logic        mf_request_flag,
  input wire logic        op_failed_flag
);
  localparam int WR_LEN = WRITE_TIME_US * (`DEA_CLK_HZ / `DEA_US_PER_S);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Decoded bus events seen by several properties.
  wire       ctrl_take = avs_write && !avs_waitrequest && avs_address == `DEA_OFF_INDIRECT;
  wire       stat_clr  = avs_write && !avs_waitrequest && avs_address == `DEA_OFF_STATUS;
  wire [3:0] stat_now  = {nvm_busy, op_failed_flag, mf_request_flag, program_done_flag};

  // Length of the running cycle; a write is far too long to unroll, so it is counted.
  logic [19:0] busy_len;
  logic        was_read;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_len <= 20'h0_0000;
      was_read <= 1'b0;
    end else begin
      busy_len <= nvm_busy ? busy_len + 20'h0_0001 : 20'h0_0000;
      was_read <= nvm_busy ? was_read : avs_writedata[0];
    end
  end

  sequence s_end_ok;
    $fell(nvm_busy) && !$past(low_power_request);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  property p_one_wait;
    $rose(avs_read || avs_write) |-> s_one_wait;
  endproperty
  property p_addr_hi_zero;
    avs_read && !avs_waitrequest && avs_address == `DEA_OFF_ADDRESS |-> avs_readdata[31:6] == '0;
  endproperty
  property p_status_view;
    avs_read && !avs_waitrequest && avs_address == `DEA_OFF_STATUS
      |-> avs_readdata[3:0] == $past(stat_now);
  endproperty
  property p_start_source;
    $rose(nvm_busy) |-> $past(ctrl_take);
  endproperty
  property p_read_len;
    s_end_ok ##0 was_read |-> busy_len == READ_CYCLES;
  endproperty
  property p_write_len;
    s_end_ok ##0 !was_read |-> busy_len >= WR_LEN && busy_len <= WR_LEN + 2;
  endproperty
  property p_write_flags;
    s_end_ok ##0 !was_read |-> program_done_flag && mf_request_flag;
  endproperty
  property p_abort;
    nvm_busy && low_power_request |=> !nvm_busy && op_failed_flag;
  endproperty
  property p_both_start;
    ctrl_take && avs_writedata[0] && avs_writedata[2] && !nvm_busy |=> !nvm_busy;
  endproperty
  property p_mf_clear;
    mf_serviced && !nvm_busy |=> !mf_request_flag;
  endproperty
  property p_done_sticky;
    program_done_flag && !stat_clr |=> program_done_flag;
  endproperty
  property p_reset_clear;
    disable iff (1'b0) reset |-> stat_now == 4'h0;
  endproperty

  a_one_wait:     assert property (p_one_wait) else $error("wait state count wrong");
  a_addr_hi_zero: assert property (p_addr_hi_zero) else $error("address high bits set");
  a_status_view:  assert property (p_status_view) else $error("status mismatch");
  a_start_source: assert property (p_start_source) else $error("cycle without start");
  a_read_len:     assert property (p_read_len) else $error("read length wrong");
  a_write_len:    assert property (p_write_len) else $error("write length wrong");
  a_write_flags:  assert property (p_write_flags) else $error("write flags missing");
  a_abort:        assert property (p_abort) else $error("abort not taken");
  a_both_start:   assert property (p_both_start) else $error("double start ran");
  a_mf_clear:     assert property (p_mf_clear) else $error("service flag kept");
  a_done_sticky:  assert property (p_done_sticky) else $error("done flag lost");
  a_reset_clear:  assert property (p_reset_clear) else $error("flags set in reset");
endmodule // dea_access_ctrl_checker

bind dea_access_ctrl dea_access_ctrl_checker #(
  .READ_CYCLES(READ_CYCLES), .WRITE_TIME_US(WRITE_TIME_US)
) u_chk (
  .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .low_power_request(low_power_request), .mf_serviced(mf_serviced), .nvm_busy(nvm_busy),
  .program_done_flag(program_done_flag), .mf_request_flag(mf_request_flag),
  .op_failed_flag(op_failed_flag)
);

// ==== test/dea_access_ctrl_tb_top.sv ====
// Self-checking bench for the data EEPROM access controller, driving its ports directly.
// Assumes the design package files are compiled first; the write time is shortened.
`timescale 1ns/1ps
`include "dea_map.svh"

module dea_access_ctrl_tb_top;
  localparam int WR_US = 3;
  // Design inputs.
  logic        clk = 1'b0;
  logic        reset = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        low_power_request = 1'b0;
  logic        mf_serviced = 1'b0;
  // Design outputs.
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, nvm_busy, program_done_flag, mf_request_flag, op_failed_flag;
  // Bench state.
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'h0000_B91A;
  logic [31:0] q;
  logic        global_irq_enable = 1'b1;
  logic [7:0]  shadow [64];
  logic [5:0]  a;
  logic [5:0]  used [$];

  dea_access_ctrl #(.WRITE_TIME_US(WR_US)) u_dut (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .low_power_request(low_power_request), .mf_serviced(mf_serviced), .nvm_busy(nvm_busy),
    .program_done_flag(program_done_flag), .mf_request_flag(mf_request_flag),
    .op_failed_flag(op_failed_flag)
  );

  // The 10 MHz system clock.
  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected status word: busy, fail, service flag, done from high to low.
  function automatic logic [31:0] stat_exp(input logic b, f, m, d);
    return {28'h000_0000, b, f, m, d};
  endfunction

  task automatic close_out();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One Avalon access, held until the rising edge that samples waitrequest low; one idle
  // cycle follows, so the next request rises from a released bus.
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= ad;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
    if (n == 20) check("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0);
    check(what, exp, q);
  endtask

  // Polls a start bit as software would, with a bound on the number of reads.
  task automatic poll_clear(input int bitpos);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `DEA_OFF_INDIRECT, 32'h0);
      n++;
    end while (q[bitpos] !== 1'b0 && n < 100);
    check("start bit", 32'h0, {31'h0, q[bitpos]});
  endtask

  task automatic nvm_write(input logic [5:0] ad, input logic [7:0] d, input logic wt);
    xfer(1'b1, `DEA_OFF_ADDRESS, {26'h0, ad});
    xfer(1'b1, `DEA_OFF_DATA, {24'h0, d});
    global_irq_enable = 1'b0;
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_0008);
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_000C);
    global_irq_enable = 1'b1;
    if (wt) begin
      rd_chk("ctrl in write", `DEA_OFF_INDIRECT, 32'h0000_000C);
      poll_clear(2);
    end
  endtask

  task automatic nvm_read(input logic [7:0] ad, input logic [7:0] exp);
    xfer(1'b1, `DEA_OFF_ADDRESS, {24'h0, ad});
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_0002);
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_0003);
    poll_clear(0);
    rd_chk("fetched byte", `DEA_OFF_DATA, {24'h0, exp});
  endtask

  // A hang is cut short after far more cycles than the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      close_out();
    end
  end

  // Main sequence; reset rises at time zero so the design sees an edge on it.
  initial begin
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd_chk("reset value", 8'(i * 4), 32'h0);
    seed = xorshift(seed);
    xfer(1'b1, `DEA_OFF_ADDRESS, seed);
    rd_chk("address reg", `DEA_OFF_ADDRESS, {26'h0, seed[5:0]});
    xfer(1'b1, 8'h18, 32'h0000_00FF);
    rd_chk("unmapped", 8'h18, 32'h0);
    rd_chk("unaligned", 8'h02, 32'h0);
    avs_byteenable <= 4'hE;
    xfer(1'b1, `DEA_OFF_DATA, 32'h0000_005A);
    avs_byteenable <= 4'hF;
    rd_chk("masked write", `DEA_OFF_DATA, 32'h0);
    // The control register is out of reach until both pointer bytes select it.
    xfer(1'b1, `DEA_OFF_PTR_LOW, {24'h0, `DEA_CTRL_PTR_LOW});
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_000A);
    xfer(1'b1, `DEA_OFF_PTR_HIGH, {24'h0, `DEA_CTRL_PTR_HIGH});
    rd_chk("locked ctrl", `DEA_OFF_INDIRECT, 32'h0);
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_0001);
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_0004);
    check("busy without permit", 32'h0, {31'h0, nvm_busy});
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_000A);
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0000_000F);
    rd_chk("double start", `DEA_OFF_INDIRECT, 32'h0000_000A);
    xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0);
    rd_chk("permits cleared", `DEA_OFF_INDIRECT, 32'h0);
    // Writes at both ends of the address range and at random places.
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      a = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : seed[13:8];
      shadow[a] = seed[7:0];
      used.push_back(a);
      nvm_write(a, seed[7:0], 1'b1);
      rd_chk("status after write", `DEA_OFF_STATUS, stat_exp(0, 0, 1, 1));
      mf_serviced <= global_irq_enable;
      @(posedge clk);
      mf_serviced <= 1'b0;
      @(posedge clk);
      rd_chk("status serviced", `DEA_OFF_STATUS, stat_exp(0, 0, 0, 1));
      xfer(1'b1, `DEA_OFF_STATUS, 32'h0000_0001);
      xfer(1'b1, `DEA_OFF_INDIRECT, 32'h0);
    end
    foreach (used[i]) nvm_read({2'b11, used[i]}, shadow[used[i]]);
    // A low-power request in mid-write spoils the cycle and leaves storage alone.
    a = used[0];
    nvm_write(a, ~shadow[a], 1'b0);
    low_power_request <= 1'b1;
    @(posedge clk);
    low_power_request <= 1'b0;
    @(negedge clk);
    check("busy after abort", 32'h0, {31'h0, nvm_busy});
    @(posedge clk);
    rd_chk("status after abort", `DEA_OFF_STATUS, stat_exp(0, 1, 0, 0));
    xfer(1'b1, `DEA_OFF_STATUS, 32'h0000_0004);
    nvm_read({2'b00, a}, shadow[a]);
    close_out();
  end
endmodule // dea_access_ctrl_tb_top
